// *** tfs_pkg.sv ***
// Shared constants, state codes and helpers for the temperature fault supervisor.
// Assumes a 40 MHz system clock and temperature samples in signed 1/16 degree units.
package tfs_pkg;

	// Command codes of the threshold and action registers
	localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4F;
	localparam logic [7:0] CMD_OT_FAULT_ACT = 8'h50;
	localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
	localparam logic [7:0] CMD_UT_WARN_THR = 8'h52;
	localparam logic [7:0] CMD_UT_FAULT_THR = 8'h53;
	localparam logic [7:0] CMD_UT_FAULT_ACT = 8'h54;
	// Standard clear-faults command of the bus
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

	// Reset values of the registers
	localparam logic [15:0] RST_OT_FAULT_THR = 16'hEBE8;
	localparam logic [15:0] RST_OT_WARN_THR = 16'hEB70;
	localparam logic [15:0] RST_UT_WARN_THR = 16'hE580;
	localparam logic [15:0] RST_UT_FAULT_THR = 16'hE490;
	localparam logic [7:0] RST_FAULT_ACT = 8'h80;

	// Action byte fields
	localparam int ACT_BEHAV_HI = 7;
	localparam int ACT_BEHAV_LO = 6;
	localparam int ACT_RETRY_HI = 5;
	localparam int ACT_RETRY_LO = 3;
	localparam int ACT_TIME_HI = 2;
	localparam int ACT_TIME_LO = 0;

	// Response behaviour codes
	localparam logic [1:0] BEHAV_IGNORE = 2'h0;
	localparam logic [1:0] BEHAV_DELAY_OFF = 2'h1;
	localparam logic [1:0] BEHAV_OFF_NOW = 2'h2;
	localparam logic [1:0] BEHAV_HOLD_OFF = 2'h3;

	// Retry codes
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// Linear-11 word fields and internal temperature scale
	localparam int L11_EXP_HI = 15;
	localparam int L11_EXP_LO = 11;
	localparam int L11_MANT_HI = 10;
	localparam int TEMP_FRAC_BITS = 4;

	// Temperature status bit positions
	localparam int STAT_UT_FAULT = 0;
	localparam int STAT_UT_WARN = 1;
	localparam int STAT_OT_WARN = 2;
	localparam int STAT_OT_FAULT = 3;

	// Timing: unit of the action time field
	localparam int CLK_FREQ_MHZ = 40;
	localparam int TIME_UNIT_US = 1000;
	localparam int TMR_W = 24;

	// One-hot states of a fault response sequencer
	typedef enum logic [4:0] {
		SEQ_RUN = 5'h01,
		SEQ_DELAY = 5'h02,
		SEQ_WAIT = 5'h04,
		SEQ_LATCHED = 5'h08,
		SEQ_HOLD = 5'h10
	} tfs_seq_state_t;

	// Cycles for a time field value, never less than one
	function automatic logic [TMR_W-1:0] tfs_time_cycles(input logic [2:0] t,
		input logic [TMR_W-1:0] unit);
		logic [TMR_W-1:0] prod;
		prod = TMR_W'(t * unit);
		return (t == 3'h0) ? TMR_W'(1) : prod;
	endfunction

	// Linear-11 word to signed value in 1/16 degree units
	function automatic logic signed [31:0] tfs_l11_to_q4(input logic [15:0] w);
		logic signed [4:0] e;
		logic signed [31:0] m;
		logic signed [6:0] sh;
		e = w[L11_EXP_HI:L11_EXP_LO];
		m = 32'(signed'(w[L11_MANT_HI:0]));
		sh = 7'(e) + 7'(TEMP_FRAC_BITS);
		if (sh >= 0) begin
			return m <<< sh;
		end
		return m >>> (-sh);
	endfunction

endpackage

// *** tfs_fault_seq.sv ***
// Fault response sequencer for one temperature fault source.
// Assumes fault_i is a hysteretic level and run_i is the host enable of the rail.
`timescale 1ns/10ps
module tfs_fault_seq #(
	parameter logic [tfs_pkg::TMR_W-1:0] UNIT_CYCLES = tfs_pkg::TMR_W'(40000)
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic run_i,
	input wire logic fault_i,
	input wire logic [7:0] action_i,
	output logic rail_ok_o,
	output logic latched_o
);
	import tfs_pkg::*;

	tfs_seq_state_t state, next_state; // Sequencer state
	logic [TMR_W-1:0] tmr, next_tmr; // Delay and retry interval timer
	logic [2:0] tries, next_tries; // Restart attempts made
	logic [1:0] behav; // Response behaviour field
	logic [2:0] retry; // Retry field
	logic [TMR_W-1:0] span; // Programmed time in cycles
	logic retry_left; // Another restart allowed
	tfs_seq_state_t off_state; // Where a shutdown leads

	// Field decode, same for both sources
	always_comb begin
		behav = action_i[ACT_BEHAV_HI:ACT_BEHAV_LO];
		retry = action_i[ACT_RETRY_HI:ACT_RETRY_LO];
		span = tfs_time_cycles(action_i[ACT_TIME_HI:ACT_TIME_LO], UNIT_CYCLES);
		retry_left = (retry == RETRY_FOREVER) || ((retry != RETRY_NONE) && (tries < retry));
		off_state = retry_left ? SEQ_WAIT : SEQ_LATCHED;
	end

	// Next state of the sequencer
	always_comb begin
		next_state = state;
		next_tmr = tmr;
		next_tries = tries;
		if (!run_i) begin
			// Host disable restarts the sequence
			next_state = SEQ_RUN;
			next_tmr = '0;
			next_tries = 3'h0;
		end else begin
			unique case (state)
				SEQ_RUN: begin
					if (fault_i) begin
						unique case (behav)
							BEHAV_IGNORE: next_state = SEQ_RUN;
							BEHAV_DELAY_OFF: begin
								next_state = SEQ_DELAY;
								next_tmr = span;
							end
							BEHAV_OFF_NOW: begin
								next_state = off_state;
								next_tmr = span;
							end
							BEHAV_HOLD_OFF: next_state = SEQ_HOLD;
						endcase
					end
				end
				SEQ_DELAY: begin
					// Count down, then shut down
					if (tmr <= TMR_W'(1)) begin
						next_state = off_state;
						next_tmr = span;
					end else begin
						next_tmr = tmr - TMR_W'(1);
					end
				end
				SEQ_WAIT: begin
					// Interval between restarts
					if (tmr <= TMR_W'(1)) begin
						next_state = SEQ_RUN;
						if (retry != RETRY_FOREVER) begin
							next_tries = tries + 3'h1;
						end
					end else begin
						next_tmr = tmr - TMR_W'(1);
					end
				end
				SEQ_LATCHED: next_state = SEQ_LATCHED;
				SEQ_HOLD: begin
					if (!fault_i) begin
						next_state = SEQ_RUN;
					end
				end
				default: next_state = SEQ_RUN;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= SEQ_RUN;
			tmr <= '0;
			tries <= 3'h0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			tries <= next_tries;
		end
	end

	// Rail allowed while running or still in the delay
	assign rail_ok_o = (state == SEQ_RUN) || (state == SEQ_DELAY);
	assign latched_o = (state == SEQ_LATCHED);

endmodule

// *** tfs_temp_supervisor.sv ***
// Temperature fault supervisor: thresholds, hysteretic fault flags, sticky status,
// host notification and per-source fault response sequencing.
// Assumes commands arrive already decoded from the bus as one-cycle strobes, and
// temperature samples come from logic on the same clock in signed 1/16 degree units.
`timescale 1ns/10ps
module tfs_temp_supervisor #(
	parameter logic [tfs_pkg::TMR_W-1:0] TIME_UNIT_CYCLES =
		tfs_pkg::TMR_W'(tfs_pkg::TIME_UNIT_US * tfs_pkg::CLK_FREQ_MHZ)
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic cmd_unsup_o,
	input wire logic signed [15:0] temp_q4_i,
	input wire logic temp_valid_i,
	input wire logic enable_i,
	output logic rail_enable_o,
	output logic [3:0] status_temp_o,
	output logic temp_summary_o,
	output logic alert_n_o,
	output logic ot_fault_active_o,
	output logic ut_fault_active_o
);
	import tfs_pkg::*;

	// Register file
	logic [15:0] ot_fault_thr, next_ot_fault_thr; // Over-temp fault threshold
	logic [15:0] ot_warn_thr, next_ot_warn_thr; // Over-temp warning threshold
	logic [15:0] ut_warn_thr, next_ut_warn_thr; // Under-temp warning threshold
	logic [15:0] ut_fault_thr, next_ut_fault_thr; // Under-temp fault threshold
	logic [7:0] ot_act, next_ot_act; // Over-temp fault action
	logic [7:0] ut_act, next_ut_act; // Under-temp fault action
	logic clear_faults; // Clear-faults strobe

	// Read answer
	logic [15:0] next_rd_data; // Read data next value
	logic next_rd_valid; // Read strobe next value
	logic next_cmd_unsup; // Unknown command next value
	logic code_known; // Code matches a register

	// Comparison path
	logic signed [31:0] temp_ext; // Sample at comparison width
	logic above_ot_fault; // Hotter than fault threshold
	logic above_ot_warn; // Hotter than warning threshold
	logic below_ot_warn; // Cooler than over-temp warning
	logic below_ut_fault; // Colder than fault threshold
	logic below_ut_warn; // Colder than warning threshold
	logic above_ut_warn; // Warmer than under-temp warning

	// Hysteretic fault levels and sticky status
	logic ot_fault, next_ot_fault; // Over-temp fault level
	logic ut_fault, next_ut_fault; // Under-temp fault level
	logic [3:0] status, next_status; // Sticky temperature status
	logic alert_n, next_alert_n; // Host notify line

	// Sequencer outputs
	logic ot_rail_ok; // Over-temp sequencer allows rail
	logic ut_rail_ok; // Under-temp sequencer allows rail
	logic rail_en, next_rail_en; // Registered rail enable

	// Register writes and the clear-faults command
	always_comb begin
		next_ot_fault_thr = ot_fault_thr;
		next_ot_warn_thr = ot_warn_thr;
		next_ut_warn_thr = ut_warn_thr;
		next_ut_fault_thr = ut_fault_thr;
		next_ot_act = ot_act;
		next_ut_act = ut_act;
		clear_faults = 1'b0;
		if (cmd_valid_i && cmd_write_i) begin
			unique case (cmd_code_i)
				CMD_OT_FAULT_THR: next_ot_fault_thr = cmd_wdata_i;
				CMD_OT_FAULT_ACT: next_ot_act = cmd_wdata_i[7:0];
				CMD_OT_WARN_THR: next_ot_warn_thr = cmd_wdata_i;
				CMD_UT_WARN_THR: next_ut_warn_thr = cmd_wdata_i;
				CMD_UT_FAULT_THR: next_ut_fault_thr = cmd_wdata_i;
				CMD_UT_FAULT_ACT: next_ut_act = cmd_wdata_i[7:0];
				CMD_CLEAR_FAULTS: clear_faults = 1'b1;
				default: clear_faults = 1'b0;
			endcase
		end
	end

	// Register file storage with documented reset values
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ot_fault_thr <= RST_OT_FAULT_THR;
			ot_warn_thr <= RST_OT_WARN_THR;
			ut_warn_thr <= RST_UT_WARN_THR;
			ut_fault_thr <= RST_UT_FAULT_THR;
			ot_act <= RST_FAULT_ACT;
			ut_act <= RST_FAULT_ACT;
		end else begin
			ot_fault_thr <= next_ot_fault_thr;
			ot_warn_thr <= next_ot_warn_thr;
			ut_warn_thr <= next_ut_warn_thr;
			ut_fault_thr <= next_ut_fault_thr;
			ot_act <= next_ot_act;
			ut_act <= next_ut_act;
		end
	end

	// Read data and unknown command detection
	always_comb begin
		next_rd_data = rd_data_o;
		code_known = 1'b1;
		unique case (cmd_code_i)
			CMD_OT_FAULT_THR: next_rd_data = ot_fault_thr;
			CMD_OT_FAULT_ACT: next_rd_data = {8'h00, ot_act};
			CMD_OT_WARN_THR: next_rd_data = ot_warn_thr;
			CMD_UT_WARN_THR: next_rd_data = ut_warn_thr;
			CMD_UT_FAULT_THR: next_rd_data = ut_fault_thr;
			CMD_UT_FAULT_ACT: next_rd_data = {8'h00, ut_act};
			CMD_CLEAR_FAULTS: begin
				// Write only; reads as zero
				next_rd_data = 16'h0000;
				code_known = cmd_write_i;
			end
			default: begin
				next_rd_data = 16'h0000;
				code_known = 1'b0;
			end
		endcase
		if (!(cmd_valid_i && !cmd_write_i)) begin
			// Hold the last answer between reads
			next_rd_data = rd_data_o;
		end
		next_rd_valid = cmd_valid_i && !cmd_write_i;
		next_cmd_unsup = cmd_valid_i && !code_known;
	end

	// Read answer registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_data_o <= 16'h0000;
			rd_valid_o <= 1'b0;
			cmd_unsup_o <= 1'b0;
		end else begin
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
			cmd_unsup_o <= next_cmd_unsup;
		end
	end

	// Threshold comparisons against decoded words
	always_comb begin
		temp_ext = 32'(temp_q4_i);
		above_ot_fault = temp_ext > tfs_l11_to_q4(ot_fault_thr);
		above_ot_warn = temp_ext > tfs_l11_to_q4(ot_warn_thr);
		below_ot_warn = temp_ext < tfs_l11_to_q4(ot_warn_thr);
		below_ut_fault = temp_ext < tfs_l11_to_q4(ut_fault_thr);
		below_ut_warn = temp_ext < tfs_l11_to_q4(ut_warn_thr);
		above_ut_warn = temp_ext > tfs_l11_to_q4(ut_warn_thr);
	end

	// Fault levels with hysteresis against the warning thresholds
	always_comb begin
		next_ot_fault = ot_fault;
		next_ut_fault = ut_fault;
		if (temp_valid_i) begin
			if (above_ot_fault) begin
				next_ot_fault = 1'b1;
			end else if (below_ot_warn) begin
				next_ot_fault = 1'b0;
			end
			if (below_ut_fault) begin
				next_ut_fault = 1'b1;
			end else if (above_ut_warn) begin
				next_ut_fault = 1'b0;
			end
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_comb begin
		next_status = status;
		if (clear_faults) begin
			next_status = 4'h0;
		end
		if (temp_valid_i && above_ot_warn) begin
			next_status[STAT_OT_WARN] = 1'b1;
		end
		if (temp_valid_i && below_ut_warn) begin
			next_status[STAT_UT_WARN] = 1'b1;
		end
		if (next_ot_fault) begin
			next_status[STAT_OT_FAULT] = 1'b1;
		end
		if (next_ut_fault) begin
			next_status[STAT_UT_FAULT] = 1'b1;
		end
		next_alert_n = ~(|next_status);
		next_rail_en = enable_i && ot_rail_ok && ut_rail_ok;
	end

	// Fault, status, notify and rail registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ot_fault <= 1'b0;
			ut_fault <= 1'b0;
			status <= 4'h0;
			alert_n <= 1'b1;
			rail_en <= 1'b0;
		end else begin
			ot_fault <= next_ot_fault;
			ut_fault <= next_ut_fault;
			status <= next_status;
			alert_n <= next_alert_n;
			rail_en <= next_rail_en;
		end
	end

	// Over-temperature response sequencer
	tfs_fault_seq #(
		.UNIT_CYCLES(TIME_UNIT_CYCLES)
	) u_ot_seq (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.run_i(enable_i),
		.fault_i(ot_fault),
		.action_i(ot_act),
		.rail_ok_o(ot_rail_ok),
		.latched_o()
	);

	// Under-temperature response sequencer
	tfs_fault_seq #(
		.UNIT_CYCLES(TIME_UNIT_CYCLES)
	) u_ut_seq (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.run_i(enable_i),
		.fault_i(ut_fault),
		.action_i(ut_act),
		.rail_ok_o(ut_rail_ok),
		.latched_o()
	);

	// Output drive
	assign status_temp_o = status;
	assign temp_summary_o = |status;
	assign alert_n_o = alert_n;
	assign rail_enable_o = rail_en;
	assign ot_fault_active_o = ot_fault;
	assign ut_fault_active_o = ut_fault;

endmodule

// *** tfs_checker.sv ***
// Port checker of the temperature fault supervisor.
// Assumes one clock, clk_i, and the synchronous reset srst_i.
`timescale 1ns/10ps
module tfs_checker #(
	parameter logic [tfs_pkg::TMR_W-1:0] TIME_UNIT_CYCLES = tfs_pkg::TMR_W'(4)
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic cmd_unsup_o,
	input wire logic signed [15:0] temp_q4_i,
	input wire logic temp_valid_i,
	input wire logic enable_i,
	input wire logic rail_enable_o,
	input wire logic [3:0] status_temp_o,
	input wire logic temp_summary_o,
	input wire logic alert_n_o,
	input wire logic ot_fault_active_o,
	input wire logic ut_fault_active_o
);
	import tfs_pkg::*;
	logic clr_q; // Clear-faults taken at the last edge
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Remember a clear-faults command for one cycle
	always_ff @(posedge clk_i) begin
		clr_q <= !srst_i && cmd_valid_i && cmd_write_i && cmd_code_i == CMD_CLEAR_FAULTS;
	end
	chk_read_answer: assert property (cmd_valid_i && !cmd_write_i |=> rd_valid_o)
		else $error("read not answered");
	chk_write_quiet: assert property (cmd_valid_i && cmd_write_i |=> !rd_valid_o)
		else $error("write answered as read");
	chk_summary_bit: assert property (temp_summary_o == (|status_temp_o))
		else $error("summary differs from status");
	chk_alert_low: assert property (status_temp_o != 4'h0 |-> !alert_n_o)
		else $error("host not notified");
	chk_fault_flag: assert property ($rose(ot_fault_active_o) |-> status_temp_o[3])
		else $error("fault bit not set");
	chk_sticky_clear: assert property ($fell(status_temp_o[3]) || $fell(status_temp_o[0]) |-> clr_q)
		else $error("fault bit cleared without command");
	chk_ot_hold: assert property (ot_fault_active_o && !temp_valid_i |=> ot_fault_active_o)
		else $error("over fault dropped without sample");
	chk_ut_hold: assert property (ut_fault_active_o && !temp_valid_i |=> ut_fault_active_o)
		else $error("under fault dropped without sample");
	chk_rail_gate: assert property (!enable_i |=> !rail_enable_o)
		else $error("rail on while disabled");
endmodule

bind tfs_temp_supervisor tfs_checker #(.TIME_UNIT_CYCLES(TIME_UNIT_CYCLES)) tfs_checker_i (
	.clk_i, .srst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_wdata_i, .rd_data_o,
	.rd_valid_o, .cmd_unsup_o, .temp_q4_i, .temp_valid_i, .enable_i, .rail_enable_o,
	.status_temp_o, .temp_summary_o, .alert_n_o, .ot_fault_active_o, .ut_fault_active_o);

// *** tfs_host.sv ***
// Host model issuing pre-decoded bus commands to the supervisor.
// Assumes strobes change at the falling edge; answer comes one cycle after taking.
`timescale 1ns/10ps
module tfs_host (
	input wire logic clk_i,
	output logic cmd_valid_o,
	output logic cmd_write_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_wdata_o,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic cmd_unsup_i
);
	logic [15:0] last_rd; // Data of the last answer
	logic last_bad; // Refusal of the last command
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	// One command over one taking edge, answer read in the next cycle
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_code_o = code;
		cmd_wdata_o = data;
		@(negedge clk_i);
		last_rd = rd_valid_i ? rd_data_i : 16'hDEAD;
		last_bad = cmd_unsup_i;
		cmd_valid_o = 1'b0;
		// Unqualified lines carry garbage, never the old command
		cmd_code_o = ~code;
		cmd_wdata_o = ~data;
	endtask
endmodule

// *** tfs_temp_supervisor_bench.sv ***
// Self-checking bench of the temperature fault supervisor.
// Assumes the host model and checker files compile before it.
`timescale 1ns/10ps
module tfs_temp_supervisor_bench;
	import tfs_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic signed [15:0] temp = 16'sh0190; // Samples in 1/16 degree
	logic temp_v = 1'b0;
	logic en = 1'b0;
	logic cv, cw, rv, un, rail, sum, al_n, otf, utf;
	logic [7:0] cc;
	logic [15:0] cd, rdat;
	logic [3:0] st;
	int n_errors = 0;
	int check_count = 0;
	tfs_temp_supervisor #(.TIME_UNIT_CYCLES(TMR_W'(4))) tfs_temp_supervisor_i (.clk_i(clk),
		.srst_i(srst), .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_code_i(cc), .cmd_wdata_i(cd),
		.rd_data_o(rdat), .rd_valid_o(rv), .cmd_unsup_o(un), .temp_q4_i(temp),
		.temp_valid_i(temp_v), .enable_i(en), .rail_enable_o(rail), .status_temp_o(st),
		.temp_summary_o(sum), .alert_n_o(al_n), .ot_fault_active_o(otf), .ut_fault_active_o(utf));
	tfs_host tfs_host_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_code_o(cc),
		.cmd_wdata_o(cd), .rd_data_i(rdat), .rd_valid_i(rv), .cmd_unsup_i(un));
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One sample; fault flags, status and alert are settled on return
	task automatic smp(input logic [15:0] t);
		@(negedge clk);
		temp = t;
		temp_v = 1'b1;
		@(negedge clk);
		temp_v = 1'b0;
	endtask
	// Normal temperature, clear faults, restart the rail
	task automatic settle();
		smp(16'h0190);
		tfs_host_i.xfer(1'b1, 8'h03, 16'h0000);
		chk({st, al_n}, 5'h01);
		en = 1'b0;
		cyc(2);
		en = 1'b1;
		cyc(3);
		chk(rail, 1'b1);
	endtask
	task automatic t_regs();
		logic [23:0] tbl [7] = '{24'h4FEBE8, 24'h500080, 24'h51EB70, 24'h52E580, 24'h53E490,
			24'h540080, 24'h990000};
		for (int i = 0; i < 7; i++) begin
			tfs_host_i.xfer(1'b0, tbl[i][23:16], 16'h0000);
			chk(tfs_host_i.last_rd, tbl[i][15:0]);
			chk(tfs_host_i.last_bad, i == 6);
		end
	endtask
	task automatic t_ot_default();
		smp(16'h0820);
		chk({otf, st, sum, al_n}, 7'h72);
		cyc(2);
		chk(rail, 1'b0);
		smp(16'h0730);
		chk(otf, 1'b1);
		smp(16'h0640);
		chk({otf, st}, 5'h0C);
		cyc(20);
		chk(rail, 1'b0);
		settle();
	endtask
	task automatic t_ut_ignore();
		tfs_host_i.xfer(1'b1, 8'h54, 16'h0000);
		smp(16'hFC40);
		chk({utf, st, al_n}, 6'h26);
		cyc(6);
		chk(rail, 1'b1);
		smp(16'hFCE0);
		chk(utf, 1'b1);
		smp(16'hFE20);
		chk(utf, 1'b0);
		settle();
	endtask
	task automatic t_delay();
		tfs_host_i.xfer(1'b1, 8'h50, 16'h0042);
		smp(16'h0820);
		cyc(4);
		chk(rail, 1'b1);
		cyc(10);
		chk(rail, 1'b0);
		settle();
	endtask
	task automatic t_hold();
		tfs_host_i.xfer(1'b1, 8'h50, 16'h00C0);
		smp(16'h0820);
		cyc(3);
		chk(rail, 1'b0);
		smp(16'h0640);
		cyc(4);
		chk(rail, 1'b1);
		settle();
	endtask
	logic tfs_checker_prev = 1'b0; // Rail level at the last look
	// Count rail restarts while the fault stays
	task automatic t_retry();
		logic [7:0] act [4] = '{8'h89, 8'h91, 8'hB1, 8'hB9};
		int n;
		for (int k = 0; k < 4; k++) begin
			tfs_host_i.xfer(1'b1, 8'h50, {8'h00, act[k]});
			smp(16'h0820);
			n = 0;
			// Rail is still up here, so no false rise on the first look
			tfs_checker_prev = rail;
			for (int c = 0; c < 300; c++) begin
				@(negedge clk);
				n += (rail && !tfs_checker_prev) ? 1 : 0;
				tfs_checker_prev = rail;
			end
			chk(k == 3 ? 16'(n > 6) : 16'(n), k == 3 ? 16'h1 : 16'(act[k][5:3]));
			settle();
		end
	endtask
	task automatic t_own_thr();
		tfs_host_i.xfer(1'b1, 8'h4F, 16'hEA80);
		tfs_host_i.xfer(1'b0, 8'h4F, 16'h0000);
		chk(tfs_host_i.last_rd, 16'hEA80);
		smp(16'h0550);
		chk({otf, st}, 5'h18);
		settle();
		tfs_host_i.xfer(1'b1, 8'h4F, 16'hEBE8);
		// Under-temp warning moved to minus 20 degrees, a negative mantissa
		tfs_host_i.xfer(1'b1, 8'h52, 16'hE6C0);
		smp(16'hFE70);
		chk({utf, st}, 5'h02);
		settle();
		tfs_host_i.xfer(1'b1, 8'h52, 16'hE580);
	endtask
	initial begin
		cyc(20);
		srst = 1'b0;
		en = 1'b1;
		cyc(3);
		t_regs();
		t_ot_default();
		t_ut_ignore();
		t_delay();
		t_hold();
		t_retry();
		t_own_thr();
		conclude();
	end
endmodule
